/* File: i2c_mux_defs.svh */
// Constants of the four-channel two-wire bus multiplexer
`ifndef I2C_MUX_DEFS_SVH
`define I2C_MUX_DEFS_SVH

`define NUM_CH      4
`define STRAP_W     3
`define CTRL_W      3
`define CTRL_EN_BIT 2
`define CTRL_CH_MSB 1
`define CTRL_RESET  3'h0
`define ADDR_UPPER  4'h7
`define BYTE_BITS   4'h8
`define CNT_ZERO    4'h0
`define CNT_ONE     4'h1
`define IRQ_IDLE    1'b1
`define SCL_RATE_KHZ 400

`endif

/* File: i2c_mux_pkg.sv */
// Types shared by the multiplexer modules
package i2c_mux_pkg;

    typedef enum logic [1:0]
    {
        BR_IDLE = 2'h0,
        BR_UP   = 2'h1,
        BR_HOLD = 2'h3,
        BR_DOWN = 2'h2
    } bridge_state_e;

    typedef enum logic [2:0]
    {
        SL_IDLE  = 3'h0,
        SL_ADDR  = 3'h1,
        SL_ACK_A = 3'h3,
        SL_WR    = 3'h2,
        SL_ACK_W = 3'h6,
        SL_RD    = 3'h7,
        SL_ACK_R = 3'h5
    } slave_state_e;

endpackage

/* File: ctl_if.sv */
// Signals between the multiplexer core and its control-register slave
`timescale 1ns/100ps
interface ctl_if;
    logic       scl;
    logic       sda;
    logic [2:0] strap;
    logic [7:0] rd_data;
    logic       sda_drive;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic       stop_seen;

    modport mux   (output scl, sda, strap, rd_data, input sda_drive, wr_stb, wr_data, stop_seen);
    modport slave (input scl, sda, strap, rd_data, output sda_drive, wr_stb, wr_data, stop_seen);
endinterface

/* File: ctl_slave.sv */
// Two-wire bus slave serving the single control register, which the core holds
`timescale 1ns/100ps
`include "i2c_mux_defs.svh"
module ctl_slave
(
    input wire logic clk,
    input wire logic rst_n,
    ctl_if.slave     bus
);
    import i2c_mux_pkg::*;

    slave_state_e state_q;
    slave_state_e state_d;
    logic [7:0]   shift_q;
    logic [7:0]   shift_d;
    logic [3:0]   cnt_q;
    logic [3:0]   cnt_d;
    logic         rw_q;
    logic         rw_d;
    logic         drive_q;
    logic         drive_d;
    logic         wr_stb_q;
    logic         wr_stb_d;
    logic         stop_q;
    logic         scl_prev_q;
    logic         sda_prev_q;

    wire scl_rise   = bus.scl & ~scl_prev_q;
    wire scl_fall   = ~bus.scl & scl_prev_q;
    wire start_cond = bus.scl & scl_prev_q & sda_prev_q & ~bus.sda;
    wire stop_cond  = bus.scl & scl_prev_q & ~sda_prev_q & bus.sda;
    wire byte_done  = (cnt_q == `BYTE_BITS);
    wire addr_match = (shift_q[7:1] == {`ADDR_UPPER, bus.strap});

    assign bus.sda_drive = drive_q;
    assign bus.wr_stb    = wr_stb_q;
    assign bus.wr_data   = shift_q;
    assign bus.stop_seen = stop_q;

    always_comb
    begin
        state_d  = state_q;
        shift_d  = shift_q;
        cnt_d    = cnt_q;
        rw_d     = rw_q;
        drive_d  = drive_q;
        wr_stb_d = 1'b0;
        if (stop_cond)
        begin
            state_d = SL_IDLE;
            drive_d = 1'b0;
        end
        else if (start_cond)
        begin
            state_d = SL_ADDR;
            cnt_d   = `CNT_ZERO;
            drive_d = 1'b0;
        end
        else
        begin
            case (state_q)
                SL_IDLE:
                begin
                    drive_d = 1'b0;
                end
                SL_ADDR, SL_WR:
                begin
                    if (scl_rise && !byte_done)
                    begin
                        shift_d = {shift_q[6:0], bus.sda};
                        cnt_d   = cnt_q + `CNT_ONE;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        if (state_q == SL_WR)
                        begin
                            state_d  = SL_ACK_W;
                            drive_d  = 1'b1;
                            wr_stb_d = 1'b1;
                        end
                        else if (addr_match)
                        begin
                            state_d = SL_ACK_A;
                            drive_d = 1'b1;
                            rw_d    = shift_q[0];
                        end
                        else
                        begin
                            state_d = SL_IDLE;
                        end
                    end
                end
                SL_ACK_A, SL_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = `CNT_ZERO;
                        if (state_q == SL_ACK_A && rw_q)
                        begin
                            state_d = SL_RD;
                            shift_d = bus.rd_data;
                            drive_d = ~bus.rd_data[7];
                        end
                        else
                        begin
                            state_d = SL_WR;
                            drive_d = 1'b0;
                        end
                    end
                end
                SL_RD:
                begin
                    if (scl_rise && !byte_done)
                    begin
                        cnt_d = cnt_q + `CNT_ONE;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        state_d = SL_ACK_R;
                        drive_d = 1'b0;
                    end
                    else if (scl_fall)
                    begin
                        shift_d = {shift_q[6:0], 1'b0};
                        drive_d = ~shift_q[6];
                    end
                end
                SL_ACK_R:
                begin
                    // Not-acknowledge ends the read; wait for the stop
                    if (scl_rise && bus.sda)
                    begin
                        state_d = SL_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        state_d = SL_RD;
                        cnt_d   = `CNT_ZERO;
                        shift_d = bus.rd_data;
                        drive_d = ~bus.rd_data[7];
                    end
                end
                default:
                begin
                    state_d = SL_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q    <= SL_IDLE;
            shift_q    <= 8'h00;
            cnt_q      <= `CNT_ZERO;
            rw_q       <= 1'b0;
            drive_q    <= 1'b0;
            wr_stb_q   <= 1'b0;
            stop_q     <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            state_q    <= state_d;
            shift_q    <= shift_d;
            cnt_q      <= cnt_d;
            rw_q       <= rw_d;
            drive_q    <= drive_d;
            wr_stb_q   <= wr_stb_d;
            stop_q     <= stop_cond;
            scl_prev_q <= bus.scl;
            sda_prev_q <= bus.sda;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence addr_done;
        (state_q == SL_ADDR) && scl_fall && byte_done && !start_cond && !stop_cond;
    endsequence

    sequence data_done;
        (state_q == SL_WR) && scl_fall && byte_done && !start_cond && !stop_cond;
    endsequence

    own_addr_ack_a: assert property (addr_done ##0 addr_match |=> bus.sda_drive ##1 (state_q == SL_ACK_A)[*1])
        else $error("own address not acknowledged");
    foreign_addr_a: assert property (addr_done ##0 !addr_match |=> !bus.sda_drive && state_q == SL_IDLE)
        else $error("foreign address acknowledged");
    write_strobe_a: assert property (data_done |=> bus.wr_stb && bus.wr_data == $past(shift_q))
        else $error("written byte not handed on");
endmodule

/* File: i2c_chan_mux.sv */
// Four-channel two-wire bus multiplexer with combined interrupt
`timescale 1ns/100ps
`include "i2c_mux_defs.svh"
module i2c_chan_mux
(
    input  wire logic               CLK_SYS,
    input  wire logic               RST_N,
    input  wire logic               SCL_IN,
    output wire logic               SCL_OUT,
    output wire logic               SCL_OE,
    input  wire logic               SDA_IN,
    output wire logic               SDA_OUT,
    output wire logic               SDA_OE,
    input  wire logic [`STRAP_W-1:0] ADDR_STRAP,
    input  wire logic [`NUM_CH-1:0] CHAN_IRQ_IN_N,
    output wire logic               COMBINED_IRQ_OUT_N,
    input  wire logic [`NUM_CH-1:0] DOWNSTREAM_CLOCK_IN,
    output wire logic [`NUM_CH-1:0] DOWNSTREAM_CLOCK_OUT,
    output wire logic [`NUM_CH-1:0] DOWNSTREAM_CLOCK_OE,
    input  wire logic [`NUM_CH-1:0] DOWNSTREAM_DATA_IN,
    output wire logic [`NUM_CH-1:0] DOWNSTREAM_DATA_OUT,
    output wire logic [`NUM_CH-1:0] DOWNSTREAM_DATA_OE
);
    import i2c_mux_pkg::*;

    localparam int SYNC_W = `STRAP_W + 3 * `NUM_CH + 2;

    logic [SYNC_W-1:0]        sync1_q;
    logic [SYNC_W-1:0]        sync2_q;
    logic [`STRAP_W-1:0]      strap_s;
    logic [`NUM_CH-1:0]       irq_s;
    logic [`NUM_CH-1:0]       ddat_s;
    logic [`NUM_CH-1:0]       dclk_s;
    logic                     sda_s;
    logic                     scl_s;
    logic [`CTRL_W-1:0]       ctrl_q;
    logic [`CTRL_W-1:0]       pend_q;
    logic                     pend_valid_q;
    logic                     irq_q;
    logic [1:0]               up_in;
    logic [1:0]               down_in;
    logic [1:0]               up_pull;
    logic [1:0]               down_pull;
    logic [1:0]               line_idle;
    logic [`NUM_CH-1:0]       chan_onehot;
    ctl_if                    ctl ();

    // Every input pin but RST_N, straps included, crosses two flops before use
    always_ff @(posedge CLK_SYS)
    begin
        sync1_q <= {ADDR_STRAP, CHAN_IRQ_IN_N, DOWNSTREAM_DATA_IN, DOWNSTREAM_CLOCK_IN,
                    SDA_IN, SCL_IN};
        sync2_q <= sync1_q;
    end
    assign {strap_s, irq_s, ddat_s, dclk_s, sda_s, scl_s} = sync2_q;

    wire                     chan_en  = ctrl_q[`CTRL_EN_BIT];
    wire [`CTRL_CH_MSB:0]    chan_sel = ctrl_q[`CTRL_CH_MSB:0];

    assign chan_onehot = chan_en ? (`NUM_CH'(1) << chan_sel) : '0;
    assign up_in       = {sda_s, scl_s};
    assign down_in     = {ddat_s[chan_sel], dclk_s[chan_sel]};

    assign ctl.scl     = scl_s;
    assign ctl.sda     = sda_s;
    assign ctl.strap   = strap_s;
    assign ctl.rd_data = {~irq_s, 1'b0, ctrl_q};

    ctl_slave u_slave
    (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .bus   (ctl)
    );

    // Per-line direction arbiter; HOLD waits for both sides to read high so
    // that the echo of our own pull never turns the direction round.
    // Limitation: a downstream clock stretch begun while in HOLD is not forwarded.
    for (genvar l = 0; l < 2; l++)
    begin : g_line
        bridge_state_e st_q;
        bridge_state_e st_d;

        always_comb
        begin
            st_d = st_q;
            case (st_q)
                BR_IDLE:
                begin
                    if (chan_en && !up_in[l])
                    begin
                        st_d = BR_UP;
                    end
                    else if (chan_en && !down_in[l])
                    begin
                        st_d = BR_DOWN;
                    end
                end
                BR_UP:
                begin
                    if (up_in[l])
                    begin
                        st_d = BR_HOLD;
                    end
                end
                BR_DOWN:
                begin
                    if (down_in[l])
                    begin
                        st_d = BR_HOLD;
                    end
                end
                BR_HOLD:
                begin
                    if (up_in[l] && down_in[l])
                    begin
                        st_d = BR_IDLE;
                    end
                end
                default:
                begin
                    st_d = BR_IDLE;
                end
            endcase
        end

        always_ff @(posedge CLK_SYS)
        begin
            if (!RST_N)
            begin
                st_q <= BR_IDLE;
            end
            else
            begin
                st_q <= st_d;
            end
        end

        assign down_pull[l] = (st_q == BR_UP);
        assign up_pull[l]   = (st_q == BR_DOWN);
        assign line_idle[l] = (st_q == BR_IDLE);
    end

    // New selection takes effect at the stop so a frame is never cut in half
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            ctrl_q       <= `CTRL_RESET;
            pend_q       <= `CTRL_RESET;
            pend_valid_q <= 1'b0;
            irq_q        <= `IRQ_IDLE;
        end
        else
        begin
            irq_q <= &irq_s;
            if (ctl.wr_stb)
            begin
                pend_q       <= ctl.wr_data[`CTRL_W-1:0];
                pend_valid_q <= 1'b1;
            end
            else if (ctl.stop_seen)
            begin
                pend_valid_q <= 1'b0;
            end
            if (ctl.stop_seen && pend_valid_q)
            begin
                ctrl_q <= pend_q;
            end
        end
    end

    assign COMBINED_IRQ_OUT_N   = irq_q;
    assign SCL_OUT              = 1'b0;
    assign SDA_OUT              = 1'b0;
    assign SCL_OE               = up_pull[0];
    assign SDA_OE               = up_pull[1] | ctl.sda_drive;
    assign DOWNSTREAM_CLOCK_OUT = '0;
    assign DOWNSTREAM_DATA_OUT  = '0;
    assign DOWNSTREAM_CLOCK_OE  = chan_onehot & {`NUM_CH{down_pull[0]}};
    assign DOWNSTREAM_DATA_OE   = chan_onehot & {`NUM_CH{down_pull[1]}};

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence write_then_stop;
        pend_valid_q && ctl.stop_seen && !ctl.wr_stb;
    endsequence

    sequence master_pulls_clock;
        chan_en && line_idle[0] && !scl_s;
    endsequence

    one_channel_a: assert property ($onehot0(DOWNSTREAM_CLOCK_OE) && $onehot0(DOWNSTREAM_DATA_OE))
        else $error("more than one channel driven");
    deselect_quiet_a: assert property (!chan_en |-> DOWNSTREAM_CLOCK_OE == '0 && DOWNSTREAM_DATA_OE == '0)
        else $error("channel driven while deselected");
    ctrl_apply_a: assert property (write_then_stop |=> ctrl_q == $past(pend_q))
        else $error("selection not applied at stop");
    ctrl_hold_a: assert property (!(ctl.stop_seen && pend_valid_q) |=> $stable(ctrl_q))
        else $error("selection changed without a write");
    irq_assert_a: assert property ((irq_s != {`NUM_CH{1'b1}}) |=> !COMBINED_IRQ_OUT_N)
        else $error("interrupt output not asserted");
    irq_release_a: assert property ((irq_s == {`NUM_CH{1'b1}}) |=> COMBINED_IRQ_OUT_N)
        else $error("interrupt output stuck low");
    reset_clear_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
        !RST_N |=> ctrl_q == `CTRL_RESET && DOWNSTREAM_CLOCK_OE == '0)
        else $error("reset left a channel selected");
    clock_follow_a: assert property (master_pulls_clock |=> (DOWNSTREAM_CLOCK_OE == chan_onehot))
        else $error("upstream clock low not forwarded");
endmodule

/* File: i2c_up_master.sv */
// Upstream two-wire bus master model that programs the multiplexer
`timescale 1ns/100ps
module i2c_up_master
#(
    parameter int HALF = 32
)
(
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Channel choice reaches the device only through these frames
    task automatic bus_start();
        sda_low <= 1'b1;
        wait_cyc(HALF);
        scl_low <= 1'b1;
        wait_cyc(HALF);
    endtask

    // 64-cycle clock period keeps the bus just under 400 kHz
    task automatic bus_bit(input logic b, output logic r);
        wait_cyc(2);
        sda_low <= !b;
        wait_cyc(HALF - 2);
        scl_low <= 1'b0;
        wait_cyc(HALF / 2);
        // A stretched clock must be waited out before sampling
        while (scl !== 1'b1)
            wait_cyc(1);
        @(negedge clk);
        r = sda;
        wait_cyc(HALF / 2);
        scl_low <= 1'b1;
    endtask

    task automatic bus_byte(input logic [7:0] b, input logic ack_in,
                            output logic [7:0] r, output logic ack_out);
        logic x;
        for (int i = 7; i >= 0; i--)
        begin
            bus_bit(b[i], x);
            r[i] = x;
        end
        bus_bit(ack_in, ack_out);
    endtask

    task automatic bus_stop();
        wait_cyc(2);
        sda_low <= 1'b1;
        wait_cyc(HALF);
        scl_low <= 1'b0;
        wait_cyc(HALF);
        sda_low <= 1'b0;
        wait_cyc(HALF);
    endtask

    task automatic hold(input logic c, input logic d);
        scl_low <= c;
        sda_low <= d;
    endtask
endmodule

/* File: i2c_chan_mux_tb_top.sv */
// Self-checking bench for the four-channel bus multiplexer
`timescale 1ns/100ps
`include "i2c_mux_defs.svh"
`define CHK(n, e, g) begin @(negedge clk_sys); num_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end @(posedge clk_sys); end
module i2c_chan_mux_tb_top;
    localparam logic [2:0] STRAP = 3'h5;
    logic       clk_sys;
    logic       rst_n;
    logic [3:0] irq_n;
    logic [3:0] ds_clk_low;
    logic       scl_oe;
    logic       sda_oe;
    logic       irq_out_n;
    logic [3:0] ds_clk_oe;
    logic [3:0] ds_dat_oe;
    logic [2:0] strap;
    logic       scl_out;
    logic       sda_out;
    logic [3:0] ds_clk_out;
    logic [3:0] ds_dat_out;
    logic       m_scl_low;
    logic       m_sda_low;
    wire        scl_w    = !(scl_oe | m_scl_low);
    wire        sda_w    = !(sda_oe | m_sda_low);
    wire  [3:0] ds_clk_w = ~(ds_clk_oe | ds_clk_low);
    int         num_errors = 0;
    int         num_checks = 0;

    i2c_chan_mux u_dut
    (
        .CLK_SYS              (clk_sys),
        .RST_N                (rst_n),
        .SCL_IN               (scl_w),
        .SCL_OUT              (scl_out),
        .SCL_OE               (scl_oe),
        .SDA_IN               (sda_w),
        .SDA_OUT              (sda_out),
        .SDA_OE               (sda_oe),
        .ADDR_STRAP           (strap),
        .CHAN_IRQ_IN_N        (irq_n),
        .COMBINED_IRQ_OUT_N   (irq_out_n),
        .DOWNSTREAM_CLOCK_IN  (ds_clk_w),
        .DOWNSTREAM_CLOCK_OUT (ds_clk_out),
        .DOWNSTREAM_CLOCK_OE  (ds_clk_oe),
        .DOWNSTREAM_DATA_IN   (~ds_dat_oe),
        .DOWNSTREAM_DATA_OUT  (ds_dat_out),
        .DOWNSTREAM_DATA_OE   (ds_dat_oe)
    );

    i2c_up_master u_master
    (
        .clk     (clk_sys),
        .scl     (scl_w),
        .sda     (sda_w),
        .scl_low (m_scl_low),
        .sda_low (m_sda_low)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr_ctrl(input logic [2:0] a, input logic [7:0] d, output logic ack);
        logic [7:0] r;
        logic       k;
        u_master.bus_start();
        u_master.bus_byte({`ADDR_UPPER, a, 1'b0}, 1'b1, r, ack);
        if (ack === 1'b0)
            u_master.bus_byte(d, 1'b1, r, k);
        u_master.bus_stop();
    endtask

    task automatic rd_ctrl(output logic [7:0] d);
        logic [7:0] r;
        logic       k;
        u_master.bus_start();
        u_master.bus_byte({`ADDR_UPPER, STRAP, 1'b1}, 1'b1, r, k);
        `CHK("read ack", 1'b0, k)
        u_master.bus_byte(8'hFF, 1'b1, d, k);
        u_master.bus_stop();
    endtask

    // Bare clock and data lows show which downstream pair is joined
    task automatic chk_sel(input logic [3:0] e);
        u_master.hold(1'b1, 1'b0);
        wait_cyc(8);
        u_master.hold(1'b1, 1'b1);
        wait_cyc(8);
        `CHK("clock select", e, ds_clk_oe)
        `CHK("data select", e, ds_dat_oe)
        u_master.hold(1'b1, 1'b0);
        wait_cyc(8);
        u_master.hold(1'b0, 1'b0);
        wait_cyc(10);
        `CHK("clock released", 4'h0, ds_clk_oe)
    endtask

    task automatic t_reset();
        rst_n <= 1'b0;
        wait_cyc(5);
        `CHK("reset clock oe", 4'h0, ds_clk_oe)
        `CHK("reset data oe", 4'h0, ds_dat_oe)
        `CHK("reset sda oe", 1'b0, sda_oe)
        `CHK("reset irq", 1'b1, irq_out_n)
        `CHK("pin levels", 10'h000, {scl_out, sda_out, ds_clk_out, ds_dat_out})
        rst_n <= 1'b1;
        wait_cyc(5);
    endtask

    task automatic t_irq();
        for (int c = 0; c < 4; c++)
        begin
            irq_n <= ~(4'h1 << c);
            wait_cyc(4);
            `CHK("irq any low", 1'b0, irq_out_n)
            irq_n <= 4'hF;
            wait_cyc(4);
            `CHK("irq all high", 1'b1, irq_out_n)
        end
    endtask

    task automatic t_select();
        logic ack;
        for (int c = 0; c < 4; c++)
        begin
            wr_ctrl(STRAP, 8'h04 | c[7:0], ack);
            `CHK("write ack", 1'b0, ack)
            chk_sel(4'h1 << c);
        end
        // Enable bit clear leaves every pair open
        wr_ctrl(STRAP, 8'h01, ack);
        chk_sel(4'h0);
    endtask

    task automatic t_foreign();
        logic       ack;
        logic [7:0] d;
        wr_ctrl(STRAP, 8'h07, ack);
        for (int a = 0; a < 8; a++)
            if (a[2:0] != STRAP)
            begin
                wr_ctrl(a[2:0], 8'h04, ack);
                `CHK("foreign nack", 1'b1, ack)
            end
        chk_sel(4'h8);
        irq_n <= 4'hA;
        rd_ctrl(d);
        `CHK("read back", 8'h57, d)
        irq_n <= 4'hF;
    endtask

    task automatic t_stretch();
        logic ack;
        wr_ctrl(STRAP, 8'h06, ack);
        ds_clk_low <= 4'h8;
        wait_cyc(8);
        `CHK("other channel stretch", 1'b0, scl_oe)
        ds_clk_low <= 4'h4;
        wait_cyc(8);
        `CHK("selected stretch", 1'b1, scl_oe)
        ds_clk_low <= 4'h0;
        wait_cyc(8);
        `CHK("stretch released", 1'b0, scl_oe)
    endtask

    task automatic t_midreset();
        logic [7:0] d;
        t_reset();
        chk_sel(4'h0);
        rd_ctrl(d);
        `CHK("ctrl after reset", 8'h00, d)
    endtask

    // Straps are live inputs; a new strap moves the slave address
    task automatic t_strap();
        logic ack;
        strap <= 3'h2;
        wait_cyc(8);
        wr_ctrl(3'h2, 8'h05, ack);
        `CHK("new strap ack", 1'b0, ack)
        wr_ctrl(STRAP, 8'h04, ack);
        `CHK("old strap nack", 1'b1, ack)
        chk_sel(4'h2);
        strap <= STRAP;
        wait_cyc(8);
    endtask

    initial
    begin
        rst_n      = 1'b0;
        irq_n      = 4'hF;
        ds_clk_low = 4'h0;
        strap      = STRAP;
        t_reset();
        t_irq();
        t_select();
        t_foreign();
        t_stretch();
        t_midreset();
        t_strap();
        stop_test();
    end

    // About 19.5k cycles of traffic expected
    initial
    begin
        wait_cyc(60000);
        num_errors++;
        stop_test();
    end
endmodule
